// File: rtl/adc_ctrl_pkg.sv
// converter control package: constants, modes and carrier structs
// assumes one 50 MHz system clock; converter clock is a prescaled tick
package adc_ctrl_pkg;
    localparam int CLK_MHZ = 50;
    localparam logic [4:0] NORMAL_CYCLES = 5'd13;
    localparam logic [4:0] FIRST_CYCLES = 5'd25;
    localparam logic [9:0] FULL_SCALE = 10'h3ff;
    localparam logic [4:0] CHANNEL_RESET = 5'h00;
    localparam logic [1:0] REFERENCE_RESET = 2'h0;
    localparam logic [6:0] PRESCALE_RESET = 7'h00;
    localparam logic [1:0] REF_PIN = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_BANDGAP = 2'h3;

    typedef enum logic [1:0] {
        SLEEP_IDLE = 2'h0,
        SLEEP_NOISE_REDUCTION = 2'h1,
        SLEEP_OTHER = 2'h2
    } sleep_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01
    } conv_state_t;

    typedef struct packed {
        logic [4:0] channel_select;
        logic [1:0] reference_select;
    } selection_t;

    typedef struct packed {
        logic analog_supply_reference;
        logic bandgap_voltage;
        logic reference_pin;
    } ref_source_t;

    typedef struct packed {
        conv_state_t st;
        selection_t hold;
        selection_t active;
        logic start_bit;
        logic start_pending;
        logic [4:0] cycle;
        logic [4:0] conv_len;
        logic first_due;
        logic done_flag;
        logic [9:0] result;
        logic [6:0] presc;
        logic trig_prev;
        logic done_prev;
        logic sleep_armed;
    } ctrl_state_t;
endpackage

// File: rtl/adc_select_buffer.sv
// converter control: selection buffering, start, timing, sleep-started conversion
// assumes all inputs come from logic on MCLK_I; the analog core supplies SAR_DATA_I
`timescale 1ns/100ps
`default_nettype none
module adc_select_buffer (
    input wire logic MCLK_I, // system clock
    input wire logic RSTN_I, // synchronous reset, active low
    input wire logic SEL_WRITE_I, // pulse: cpu writes the selection
    input wire adc_ctrl_pkg::selection_t SEL_DATA_I, // selection written
    input wire logic START_WRITE_I, // pulse: cpu writes one to the start bit
    input wire logic CONVERTER_ENABLE_I, // converter enable level
    input wire logic AUTO_TRIGGER_ENABLE_I, // auto trigger enable level
    input wire logic FREE_RUN_I, // trigger source is the done flag
    input wire logic TRIGGER_I, // external trigger source level
    input wire logic [2:0] PRESCALE_SEL_I, // converter clock = clock / 2^(sel+1); sel 7 divides by 128 like sel 6
    input wire logic DONE_CLEAR_I, // pulse: cpu clears the done flag
    input wire logic INT_ENABLE_I, // completion interrupt enable
    input wire logic SLEEP_ENTER_I, // pulse: cpu executes a sleep instruction
    input wire adc_ctrl_pkg::sleep_mode_t SLEEP_MODE_I, // mode of that sleep
    input wire logic CPU_HALTED_I, // cpu clock halted
    input wire logic [9:0] SAR_DATA_I, // result from the converter core
    input wire logic OVER_RANGE_I, // input above reference at sampling
    output logic CONV_TICK_O, // converter clock rising edge pulse
    output adc_ctrl_pkg::selection_t ACTIVE_SEL_O, // selection steering the core
    output adc_ctrl_pkg::ref_source_t REF_SOURCE_O, // decoded reference switch
    output logic SEL_LOCKED_O, // active selection frozen
    output logic START_BIT_O, // start bit readback, conversion busy
    output logic CONVERTING_O, // conversion in progress
    output logic DONE_FLAG_O, // conversion done flag
    output logic [9:0] RESULT_O, // last conversion result
    output logic IRQ_O // completion interrupt request / wake-up
);
    import adc_ctrl_pkg::*;

    ctrl_state_t s_reg, s_next;
    logic tick, locked, last_cycle, trig_edge, auto_on;

    function automatic ref_source_t decode_ref(input logic [1:0] r);
        ref_source_t d;
        d = '0;
        case (r)
            REF_PIN: d.reference_pin = 1'b1;
            REF_SUPPLY: d.analog_supply_reference = 1'b1;
            REF_BANDGAP: d.bandgap_voltage = 1'b1;
            default: d = '0; // reserved: no source switched
        endcase
        return d;
    endfunction

    always_comb begin
        auto_on = AUTO_TRIGGER_ENABLE_I && CONVERTER_ENABLE_I;
        tick = CONVERTER_ENABLE_I &&
            ((s_reg.presc & ((7'h02 << PRESCALE_SEL_I) - 7'h01)) ==
             ((7'h02 << PRESCALE_SEL_I) - 7'h01));
        last_cycle = (s_reg.st == ST_CONVERT) && (s_reg.cycle == s_reg.conv_len - 5'd1);
        // frozen from start, free again in the final converter clock
        locked = (s_reg.st == ST_CONVERT) && !last_cycle;
        trig_edge = auto_on && (FREE_RUN_I ? (s_reg.done_flag && !s_reg.done_prev)
                                           : (TRIGGER_I && !s_reg.trig_prev));
    end

    always_comb begin
        s_next = s_reg;
        s_next.trig_prev = TRIGGER_I;
        s_next.done_prev = s_reg.done_flag;
        s_next.presc = CONVERTER_ENABLE_I ? s_reg.presc + 7'h01 : PRESCALE_RESET;
        if (!CONVERTER_ENABLE_I) begin
            s_next.first_due = 1'b1;
        end
        if (SEL_WRITE_I) begin
            s_next.hold = SEL_DATA_I;
        end
        if (tick && !locked) begin
            s_next.active = s_reg.hold;
        end
        if (DONE_CLEAR_I) begin
            s_next.done_flag = 1'b0;
        end
        if (START_WRITE_I && CONVERTER_ENABLE_I) begin
            s_next.start_bit = 1'b1;
            s_next.start_pending = 1'b1;
        end
        // sleep start only in idle/noise-reduction; other modes clear sleep_armed
        if (SLEEP_ENTER_I) begin
            s_next.sleep_armed = (SLEEP_MODE_I == SLEEP_IDLE ||
                SLEEP_MODE_I == SLEEP_NOISE_REDUCTION) && CONVERTER_ENABLE_I;
        end
        if (s_reg.sleep_armed && CPU_HALTED_I && s_reg.st == ST_IDLE) begin
            s_next.sleep_armed = 1'b0;
            s_next.start_bit = 1'b1;
            s_next.start_pending = 1'b1;
        end
        if (trig_edge && s_reg.st == ST_IDLE && !FREE_RUN_I) begin
            // prescaler restarts so trigger-to-start delay is fixed
            s_next.presc = PRESCALE_RESET;
            s_next.start_bit = 1'b1;
            s_next.start_pending = 1'b1;
        end
        case (s_reg.st)
            ST_IDLE: begin
                if (tick && s_reg.start_pending) begin
                    s_next.st = ST_CONVERT;
                    s_next.start_pending = 1'b0;
                    // a start held pending over a completion must read busy again
                    s_next.start_bit = 1'b1;
                    s_next.cycle = 5'd0;
                    s_next.conv_len = s_reg.first_due ? FIRST_CYCLES : NORMAL_CYCLES;
                    s_next.first_due = 1'b0;
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (last_cycle) begin
                        s_next.result = OVER_RANGE_I ? FULL_SCALE : SAR_DATA_I;
                        s_next.done_flag = 1'b1;
                        if (auto_on && FREE_RUN_I) begin
                            // restart at once; start bit stays high
                            s_next.cycle = 5'd0;
                            s_next.conv_len = NORMAL_CYCLES;
                        end else begin
                            s_next.st = ST_IDLE;
                            s_next.start_bit = 1'b0;
                        end
                    end else begin
                        s_next.cycle = s_reg.cycle + 5'd1;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (!CONVERTER_ENABLE_I) begin
            s_next.st = ST_IDLE;
            s_next.start_bit = 1'b0;
            s_next.start_pending = 1'b0;
            s_next.sleep_armed = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.hold <= '{CHANNEL_RESET, REFERENCE_RESET};
            s_reg.active <= '{CHANNEL_RESET, REFERENCE_RESET};
            s_reg.first_due <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign CONV_TICK_O = tick;
    assign ACTIVE_SEL_O = s_reg.active;
    assign REF_SOURCE_O = decode_ref(s_reg.active.reference_select);
    assign SEL_LOCKED_O = locked;
    assign START_BIT_O = s_reg.start_bit;
    assign CONVERTING_O = (s_reg.st == ST_CONVERT);
    assign DONE_FLAG_O = s_reg.done_flag;
    assign RESULT_O = s_reg.result;
    // raised whether or not something else woke the cpu already
    assign IRQ_O = s_reg.done_flag && INT_ENABLE_I;

    property p_hold_capture;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        SEL_WRITE_I |=> s_reg.hold == $past(SEL_DATA_I);
    endproperty
    a_hold_capture: assert property (p_hold_capture)
        else $error("holding selection missed a write");

    property p_unlocked_copy;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (tick && !locked) |=> ACTIVE_SEL_O == $past(s_reg.hold);
    endproperty
    a_unlocked_copy: assert property (p_unlocked_copy)
        else $error("active selection not refreshed while unlocked");

    property p_frozen;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        locked |=> $stable(ACTIVE_SEL_O);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("active selection changed while locked");

    property p_unlock_before_done;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $rose(DONE_FLAG_O) |-> !$past(SEL_LOCKED_O);
    endproperty
    a_unlock_before_done: assert property (p_unlock_before_done)
        else $error("selection still locked in last cycle");

    property p_start_on_tick;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $rose(CONVERTING_O) |-> $past(tick) && $past(s_reg.start_pending);
    endproperty
    a_start_on_tick: assert property (p_start_on_tick)
        else $error("conversion began off a converter clock edge");

    property p_done_clears_start;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        ($rose(DONE_FLAG_O) && !($past(auto_on) && $past(FREE_RUN_I))) |-> !START_BIT_O;
    endproperty
    a_done_clears_start: assert property (p_done_clears_start)
        else $error("start bit not cleared with done flag");

    property p_length;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $rose(CONVERTING_O) |-> s_reg.cycle == 5'd0 &&
            s_reg.conv_len == ($past(s_reg.first_due) ? FIRST_CYCLES : NORMAL_CYCLES);
    endproperty
    a_length: assert property (p_length)
        else $error("conversion length wrong");

    property p_full_scale;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (tick && last_cycle && OVER_RANGE_I) |=> RESULT_O == FULL_SCALE;
    endproperty
    a_full_scale: assert property (p_full_scale)
        else $error("over-range did not give full scale");

    property p_irq;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        (tick && last_cycle) |=> DONE_FLAG_O && (IRQ_O == INT_ENABLE_I);
    endproperty
    a_irq: assert property (p_irq)
        else $error("completion request missing");

    property p_sleep_once;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $fell(s_reg.sleep_armed) && !$past(SLEEP_ENTER_I) |-> s_reg.start_pending ||
            CONVERTING_O || !CONVERTER_ENABLE_I || !$past(CONVERTER_ENABLE_I);
    endproperty
    a_sleep_once: assert property (p_sleep_once)
        else $error("sleep arm dropped without starting");
endmodule // adc_select_buffer
`default_nettype wire

// File: testbench/cpu_sleep_model.sv
// cpu sleep controller model: sleep entry, halt, wake on irq or other event
// assumes design inputs change at the falling edge of the system clock
`timescale 1ns/100ps
`default_nettype none
module cpu_sleep_model
    import adc_ctrl_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic go_i, // pulse: run a sleep instruction
    input wire sleep_mode_t mode_i, // mode to sleep in
    input wire logic other_wake_i, // another interrupt source
    input wire logic irq_i, // completion interrupt
    output logic enter_o, // sleep instruction pulse
    output sleep_mode_t mode_o, // sleep mode
    output logic halted_o // cpu clock stopped
);
    logic go_q = 1'b0, wake_q = 1'b0;
    sleep_mode_t mode_q = SLEEP_OTHER;
    initial begin
        enter_o = 1'b0;
        mode_o = SLEEP_OTHER;
        halted_o = 1'b0;
    end
    // inputs taken at the rising edge, away from the falling edge they change on
    always @(posedge clk_i) begin
        go_q <= go_i;
        mode_q <= mode_i;
        wake_q <= irq_i || other_wake_i;
    end
    // halt one cycle after the sleep instruction, as a real core would
    always @(negedge clk_i) begin
        enter_o <= go_q;
        if (go_q) begin
            mode_o <= mode_q;
        end
        if (enter_o) begin
            halted_o <= 1'b1;
        end else if (wake_q) begin
            halted_o <= 1'b0;
        end
    end
endmodule // cpu_sleep_model
`default_nettype wire

// File: testbench/adc_select_buffer_bench.sv
// bench for the converter selection buffer and sleep-started conversion
// assumes prescale select 0 (two system clocks per converter clock) but in the trigger test
`timescale 1ns/100ps
`default_nettype none
module adc_select_buffer_bench;
    import adc_ctrl_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, sel_wr = 1'b0, start_wr = 1'b0, en = 1'b0;
    logic auto_en = 1'b0, free_run = 1'b0, done_clr = 1'b0, int_en = 1'b0;
    logic over = 1'b0, go = 1'b0, other_wake = 1'b0, sl_enter, halted, trig = 1'b0;
    logic [2:0] presc_sel = 3'h0;
    logic tick, locked, start_bit, converting, done, irq;
    logic [9:0] sar = 10'h2a5, result;
    logic [2:0] ref_exp [4] = '{3'h1, 3'h4, 3'h0, 3'h2};
    selection_t sel_d = '0, active;
    sleep_mode_t mode_d = SLEEP_IDLE, sl_mode;
    ref_source_t ref_src;
    int failures = 0, samples_checked = 0, t, i;
    int conv_ticks = 0;
    always #10 mclk = ~mclk;
    // converter clocks inside the running conversion, completing one included
    always @(negedge mclk) begin
        if (converting !== 1'b1) begin
            conv_ticks <= 0;
        end else begin
            conv_ticks <= conv_ticks + int'(tick === 1'b1);
        end
    end
    cpu_sleep_model CPU (.clk_i(mclk), .go_i(go), .mode_i(mode_d),
        .other_wake_i(other_wake), .irq_i(irq), .enter_o(sl_enter), .mode_o(sl_mode),
        .halted_o(halted));
    adc_select_buffer DUT (.MCLK_I(mclk), .RSTN_I(rstn), .SEL_WRITE_I(sel_wr),
        .SEL_DATA_I(sel_d), .START_WRITE_I(start_wr), .CONVERTER_ENABLE_I(en),
        .AUTO_TRIGGER_ENABLE_I(auto_en), .FREE_RUN_I(free_run), .TRIGGER_I(trig),
        .PRESCALE_SEL_I(presc_sel), .DONE_CLEAR_I(done_clr), .INT_ENABLE_I(int_en),
        .SLEEP_ENTER_I(sl_enter), .SLEEP_MODE_I(sl_mode), .CPU_HALTED_I(halted),
        .SAR_DATA_I(sar), .OVER_RANGE_I(over), .CONV_TICK_O(tick),
        .ACTIVE_SEL_O(active), .REF_SOURCE_O(ref_src), .SEL_LOCKED_O(locked),
        .START_BIT_O(start_bit), .CONVERTING_O(converting), .DONE_FLAG_O(done),
        .RESULT_O(result), .IRQ_O(irq));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // write, then, if settle is set, let one converter tick land so the active copy can follow
    task write_sel(input selection_t s, input logic settle);
        int k;
        sel_d = s;
        sel_wr = 1'b1;
        cyc(1);
        sel_wr = 1'b0;
        for (k = 0; k < 100 && settle && tick !== 1'b1; k++) begin
            cyc(1);
        end
        cyc(1);
    endtask
    task pulse_start;
        start_wr = 1'b1;
        cyc(1);
        start_wr = 1'b0;
    endtask
    task clear_done;
        done_clr = 1'b1;
        cyc(1);
        done_clr = 1'b0;
    endtask
    // wait for the done flag; hand back the converter clocks the conversion took
    task conv(output int n);
        int k;
        for (k = 0; k < 2000 && done !== 1'b1; k++) begin
            cyc(1);
        end
        n = conv_ticks;
    endtask
    task sleep_run(input sleep_mode_t m, input logic wake_early);
        clear_done;
        mode_d = m;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(8);
        other_wake = wake_early;
        cyc(1);
        other_wake = 1'b0;
        check(converting, 1'b1);
        conv(t);
        check({done, irq}, 2'h3);
        cyc(2);
        check(halted, 1'b0);
        clear_done;
        cyc(80);
        check({converting, done}, 2'h0);
    endtask
    initial begin
        cyc(8);
        check({active, ref_src, locked, start_bit, converting, done, irq, tick},
            {7'h00, 3'h1, 6'h00});
        rstn = 1'b1;
        en = 1'b1;
        cyc(2);
        for (i = 0; i < 4; i++) begin
            write_sel({5'h1f, 2'h0}, 1'b0);
            write_sel({5'(i + 3), 2'(i)}, 1'b1);
            check(active, {5'(i + 3), 2'(i)});
            check(ref_src, ref_exp[i]);
        end
        write_sel({5'h04, 2'h1}, 1'b1);
        pulse_start;
        check(start_bit, 1'b1);
        cyc(6);
        check(locked, 1'b1);
        write_sel({5'h07, 2'h3}, 1'b0);
        cyc(6);
        check(active, {5'h04, 2'h1});
        conv(t);
        check(t, FIRST_CYCLES);
        check({result, start_bit, irq}, {sar, 2'h0});
        check(active, {5'h07, 2'h3});
        clear_done;
        over = 1'b1;
        pulse_start;
        conv(t);
        check(t, NORMAL_CYCLES);
        check(result, FULL_SCALE);
        over = 1'b0;
        clear_done;
        auto_en = 1'b1;
        free_run = 1'b1;
        pulse_start;
        conv(t);
        write_sel({5'h02, 2'h1}, 1'b0);
        cyc(4);
        check({converting, active}, {1'b1, 5'h07, 2'h3});
        clear_done;
        conv(t);
        check(active, {5'h02, 2'h1});
        free_run = 1'b0;
        auto_en = 1'b0;
        en = 1'b0;
        cyc(2);
        en = 1'b1;
        int_en = 1'b1;
        sleep_run(SLEEP_IDLE, 1'b0);
        sleep_run(SLEEP_NOISE_REDUCTION, 1'b1);
        // auto trigger on a rising trigger level, slower converter clock
        presc_sel = 3'h2;
        auto_en = 1'b1;
        trig = 1'b1;
        cyc(1);
        check(start_bit, 1'b1);
        cyc(12);
        check(converting, 1'b1);
        write_sel({5'h05, 2'h3}, 1'b0);
        check(active, {5'h02, 2'h1});
        conv(t);
        check(t, NORMAL_CYCLES);
        check({active, start_bit}, {5'h05, 2'h3, 1'b0});
        trig = 1'b0;
        auto_en = 1'b0;
        presc_sel = 3'h0;
        clear_done;
        mode_d = SLEEP_OTHER;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(80);
        check({converting, done}, 2'h0);
        summarize;
    end
    initial begin
        #(20 * 40000);
        failures++;
        summarize;
    end
endmodule // adc_select_buffer_bench
`default_nettype wire
